// ==== rtl/pvl_defines.svh ====
// Purpose: Constants for the output limit and input threshold registers
// Assumes: Command codes are those of the PMBus command space
// Notes:   Values are shared by the register bank and its testbench
`ifndef PVL_DEFINES_SVH
`define PVL_DEFINES_SVH

// Command codes
`define PVL_CMD_RATIO       8'h29
`define PVL_CMD_LOWER       8'h2b
`define PVL_CMD_START       8'h35

// Reset values
`define PVL_RATIO_RESET     16'hf004
`define PVL_LOWER_RESET     16'h00b3
`define PVL_START_RESET     16'hf012

// Fixed fields
`define PVL_EXP_M2          5'h1e
`define PVL_START_FIXED     7'h01
`define PVL_RATIO_ONE       11'h004
`define PVL_RATIO_HALF      11'h002

// Lower limit ranges, ratio 1 and ratio 0.5
`define PVL_LOWER_MIN_ONE   16'h00b3
`define PVL_LOWER_MAX_ONE   16'h0300
`define PVL_LOWER_MIN_HALF  16'h0166
`define PVL_LOWER_MAX_HALF  16'h0600

// Start threshold mantissa range
`define PVL_START_MIN       11'h011
`define PVL_START_MAX       11'h01f

// Storage slot of the start threshold
`define PVL_NV_START        2'h0

`endif

// ==== rtl/pvl_pkg.sv ====
// Purpose: Types of the output limit and input threshold registers
// Assumes: Used together with pvl_defines.svh
// Notes:   Holds types only; numbers live in the header
package pvl_pkg;

  typedef logic [15:0] pvl_word_t;
  typedef logic [10:0] pvl_mant_t;

  typedef enum logic [3:0] {
    PVL_SEL_NONE  = 4'b0001,
    PVL_SEL_RATIO = 4'b0010,
    PVL_SEL_LOWER = 4'b0100,
    PVL_SEL_START = 4'b1000
  } pvl_sel_e;

endpackage

// ==== rtl/pvl_nv_mem.sv ====
// Purpose: Small word store standing in for nonvolatile defaults
// Assumes: One write port, one read port, same clock
// Notes:   Read data come out of a register, one cycle after the address
`timescale 1ns/1ps

module pvl_nv_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("pvl_nv_mem: DEPTH must be at least 2");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];

  // No reset on the array: the contents outlive a reset by intent
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end

endmodule // pvl_nv_mem

// ==== rtl/pvl_limit_regs.sv ====
// Purpose: Feedback ratio, lower output limit and start threshold commands
// Assumes: A PMBus engine on core_clk hands over decoded command cycles
// Notes:   Status flags are sticky until statusClear; a set beats a clear
//
// How it works
// - Ratio exponent is always code minus two
// - Ratio mantissa four means 1, two 0.5
// - Reset loads ratio mantissa four
// - Ratio writes accepted in any state
// - Lower limit is unsigned, 2^-9 volts per count
// - Lower limit checked on every target change
// - Clamp reference to lower; upper wins if lower
// - Clamp sets other, summary, warning and alert
// - Loop slave: lower limit nacked, invalid command
// - Ratio 1: lower limit 179 to 768
// - Ratio 0.5: lower limit 358 to 1536
// - Start threshold in 0.25 V steps, 4.25-7.75
// - Bad start write kept out, flags, alert
// - Start must not fall below stop threshold
// - Start word: fixed exponent, four writable bits
// - Start mantissa default 18, range 17-31
// - Store-all copies start threshold to storage
// - Bad ratio write kept out, flags, alert
`timescale 1ns/1ps
`include "pvl_defines.svh"

module pvl_limit_regs
  import pvl_pkg::*;
#(
  parameter int NV_DEPTH = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWdata,
  input  wire logic        loopSlavePin,
  input  wire logic        outputOn,
  input  wire logic [15:0] targetMant,
  input  wire logic        targetChange,
  input  wire logic [15:0] upperMant,
  input  wire logic        upperChange,
  input  wire logic [10:0] stopMant,
  input  wire logic        stopReq,
  input  wire logic [10:0] stopReqMant,
  input  wire logic        statusClear,
  input  wire logic        storeAll,
  input  wire logic [1:0]  nvRdAddr,
  output logic             cmdDone,
  output logic             cmdNack,
  output logic      [15:0] cmdRdata,
  output logic             stopAccept,
  output logic             stopReject,
  output logic      [15:0] refMant,
  output logic             refClamp,
  output logic             ratioHalf,
  output logic             otherFaultFlag,
  output logic             outputVoltageSummaryFlag,
  output logic             limitWarnFlag,
  output logic             commFaultFlag,
  output logic             invalidDataFlag,
  output logic             invalidCommandFault,
  output logic             smbAlert,
  output logic      [15:0] nvRdData
);

  initial begin
    if (NV_DEPTH != 4) begin
      $error("pvl_limit_regs: NV_DEPTH must be 4");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic lowerOk(input logic [15:0] v, input logic half);
    if (half) begin
      lowerOk = (v >= `PVL_LOWER_MIN_HALF) && (v <= `PVL_LOWER_MAX_HALF);
    end else begin
      lowerOk = (v >= `PVL_LOWER_MIN_ONE) && (v <= `PVL_LOWER_MAX_ONE);
    end
  endfunction

  // Reference code is the voltage code times the ratio
  function automatic logic [15:0] scaleRef(input logic [15:0] v,
                                           input logic        half);
    scaleRef = half ? {1'b0, v[15:1]} : v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Strap synchroniser; the first stage feeds only the second

  logic slaveMeta_ff;
  logic loopSlave_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slaveMeta_ff <= 1'b0;
      loopSlave_ff <= 1'b0;
    end else begin
      slaveMeta_ff <= loopSlavePin;
      loopSlave_ff <= slaveMeta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command decode and register updates

  logic [2:0]  ratioMant_ff;
  logic [11:0] lower_ff;
  logic [3:0]  startLow_ff;
  logic        chkDly_ff;
  logic [2:0]  nxt_ratioMant;
  logic [11:0] nxt_lower;
  logic [3:0]  nxt_startLow;
  logic        nxt_chkDly;
  logic        nxt_cmdDone;
  logic        nxt_cmdNack;
  logic [15:0] nxt_cmdRdata;
  logic        nxt_stopAccept;
  logic        nxt_stopReject;
  logic        badData;
  logic        badCmd;
  pvl_sel_e    sel;
  logic [15:0] ratioWord;
  logic [15:0] lowerWord;
  logic [15:0] startWord;
  logic [10:0] startMant;

  assign startMant = {`PVL_START_FIXED, startLow_ff};
  // Exponent and upper mantissa bits are constants, never stored
  assign ratioWord = {`PVL_EXP_M2, 8'h00, ratioMant_ff};
  assign lowerWord = {4'h0, lower_ff};
  assign startWord = {`PVL_EXP_M2, startMant};

  always_comb begin
    if (cmdCode == `PVL_CMD_RATIO) begin
      sel = PVL_SEL_RATIO;
    end else if (cmdCode == `PVL_CMD_LOWER) begin
      sel = PVL_SEL_LOWER;
    end else if (cmdCode == `PVL_CMD_START) begin
      sel = PVL_SEL_START;
    end else begin
      sel = PVL_SEL_NONE;
    end
  end

  always_comb begin
    nxt_ratioMant  = ratioMant_ff;
    nxt_lower      = lower_ff;
    nxt_startLow   = startLow_ff;
    nxt_chkDly     = targetChange | upperChange;
    nxt_cmdDone    = 1'b0;
    nxt_cmdNack    = 1'b0;
    nxt_cmdRdata   = 16'h0000;
    nxt_stopAccept = 1'b0;
    nxt_stopReject = 1'b0;
    badData        = 1'b0;
    badCmd         = 1'b0;
    if (cmdValid && sel != PVL_SEL_NONE) begin
      nxt_cmdDone = 1'b1;
      case (sel)
        PVL_SEL_RATIO: begin
          nxt_cmdRdata = ratioWord;
          // No lockout on output state: accepted while running
          if (cmdWrite) begin
            if (cmdWdata[10:0] == `PVL_RATIO_ONE ||
                cmdWdata[10:0] == `PVL_RATIO_HALF) begin
              nxt_ratioMant = cmdWdata[2:0];
              nxt_chkDly    = 1'b1;
            end else begin
              badData = 1'b1;
            end
          end
        end
        PVL_SEL_LOWER: begin
          if (loopSlave_ff) begin
            nxt_cmdNack = 1'b1;
            badCmd      = 1'b1;
          end else begin
            nxt_cmdRdata = lowerWord;
            if (cmdWrite) begin
              // Writes that would leave the valid range are dropped
              if (lowerOk({4'h0, cmdWdata[11:0]}, ratioHalf)) begin
                nxt_lower  = cmdWdata[11:0];
                nxt_chkDly = 1'b1;
              end else begin
                badData = 1'b1;
              end
            end
          end
        end
        PVL_SEL_START: begin
          nxt_cmdRdata = startWord;
          if (cmdWrite) begin
            // Each mantissa count is one 0.25 V step already
            if (cmdWdata[10:0] < `PVL_START_MIN ||
                cmdWdata[10:0] > `PVL_START_MAX) begin
              badData = 1'b1;
            end else if (cmdWdata[10:0] < stopMant) begin
              badData = 1'b1;
            end else begin
              nxt_startLow = cmdWdata[3:0];
            end
          end
        end
        default: begin
          nxt_cmdDone = 1'b0;
        end
      endcase
    end
    // Stop threshold update offered by its own block
    if (stopReq) begin
      if (stopReqMant > startMant) begin
        nxt_stopReject = 1'b1;
        badData        = 1'b1;
      end else begin
        nxt_stopAccept = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Low three bits of the reset word; the rest are constants
      ratioMant_ff <= 3'h4;
      lower_ff     <= 12'h0b3;
      startLow_ff  <= 4'h2;
      chkDly_ff    <= 1'b0;
      cmdDone      <= 1'b0;
      cmdNack      <= 1'b0;
      cmdRdata     <= 16'h0000;
      stopAccept   <= 1'b0;
      stopReject   <= 1'b0;
    end else begin
      ratioMant_ff <= nxt_ratioMant;
      lower_ff     <= nxt_lower;
      startLow_ff  <= nxt_startLow;
      chkDly_ff    <= nxt_chkDly;
      cmdDone      <= nxt_cmdDone;
      cmdNack      <= nxt_cmdNack;
      cmdRdata     <= nxt_cmdRdata;
      stopAccept   <= nxt_stopAccept;
      stopReject   <= nxt_stopReject;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reference clamp and status flags

  logic        clampCond;
  logic        upperWins;
  logic [15:0] nxt_refMant;
  logic        nxt_refClamp;
  logic        nxt_other;
  logic        nxt_summary;
  logic        nxt_warn;
  logic        nxt_comm;
  logic        nxt_ivd;
  logic        nxt_ivc;
  logic        clampEvt;

  assign clampCond = outputOn && (targetMant < lowerWord);
  assign upperWins = upperMant < lowerWord;
  assign clampEvt  = chkDly_ff && clampCond;

  always_comb begin
    nxt_refClamp = clampCond;
    if (clampCond) begin
      // Upper limit dominates a crossed pair
      nxt_refMant = scaleRef(upperWins ? upperMant : lowerWord,
                             ratioHalf);
    end else begin
      nxt_refMant = scaleRef(targetMant, ratioHalf);
    end
    // Set wins over a clear in the same cycle
    nxt_other   = clampEvt | (otherFaultFlag & ~statusClear);
    nxt_summary = clampEvt | (outputVoltageSummaryFlag & ~statusClear);
    nxt_warn    = clampEvt | (limitWarnFlag & ~statusClear);
    nxt_comm    = badData | (commFaultFlag & ~statusClear);
    nxt_ivd     = badData | (invalidDataFlag & ~statusClear);
    nxt_ivc     = badCmd | (invalidCommandFault & ~statusClear);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      refMant                  <= 16'h0000;
      refClamp                 <= 1'b0;
      ratioHalf                <= 1'b0;
      otherFaultFlag           <= 1'b0;
      outputVoltageSummaryFlag <= 1'b0;
      limitWarnFlag            <= 1'b0;
      commFaultFlag            <= 1'b0;
      invalidDataFlag          <= 1'b0;
      invalidCommandFault      <= 1'b0;
      smbAlert                 <= 1'b0;
    end else begin
      refMant                  <= nxt_refMant;
      refClamp                 <= nxt_refClamp;
      ratioHalf                <= (nxt_ratioMant == 3'h2);
      otherFaultFlag           <= nxt_other;
      outputVoltageSummaryFlag <= nxt_summary;
      limitWarnFlag            <= nxt_warn;
      commFaultFlag            <= nxt_comm;
      invalidDataFlag          <= nxt_ivd;
      invalidCommandFault      <= nxt_ivc;
      smbAlert                 <= nxt_other | nxt_comm | nxt_ivc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Default storage

  pvl_nv_mem #(
    .WIDTH (16),
    .DEPTH (NV_DEPTH)
  ) u_nv (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (storeAll),
    .wrAddr   (`PVL_NV_START),
    .wrData   (startWord),
    .rdAddr   (nvRdAddr),
    .rdData   (nvRdData)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks

  ratio_exp_a: assert property (@(posedge core_clk) disable iff (rst)
    cmdValid && sel == PVL_SEL_RATIO |=>
      cmdRdata[15:11] == 5'h1e && cmdRdata[10:3] == 8'h00)
    else $error("ratio read shows a changed exponent");

  ratio_decode_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (ratioHalf == (ratioMant_ff == 3'h2)) &&
        (ratioMant_ff == 3'h2 || ratioMant_ff == 3'h4))
    else $error("ratio mantissa or decode out of step");

  ratio_any_a: assert property (@(posedge core_clk) disable iff (rst)
    cmdValid && cmdWrite && sel == PVL_SEL_RATIO &&
    cmdWdata[10:0] == 11'h002 |=> ratioMant_ff == 3'h2 ##1 ratioHalf)
    else $error("valid ratio write not taken");

  clamp_ref_a: assert property (@(posedge core_clk) disable iff (rst)
    outputOn && targetMant < lowerWord && !upperWins && !ratioHalf
    |=> refClamp && refMant == $past(lowerWord))
    else $error("reference not clamped to lower limit");

  clamp_flags_a: assert property (@(posedge core_clk) disable iff (rst)
    clampEvt |=> otherFaultFlag && outputVoltageSummaryFlag &&
                 limitWarnFlag && smbAlert)
    else $error("clamp did not raise its flags");

  slave_nack_a: assert property (@(posedge core_clk) disable iff (rst)
    cmdValid && sel == PVL_SEL_LOWER && loopSlave_ff |=>
      cmdDone && cmdNack && invalidCommandFault && smbAlert &&
      $stable(lower_ff))
    else $error("loop slave access not refused");

  lower_range_a: assert property (@(posedge core_clk) disable iff (rst)
    ##1 lowerOk(lowerWord, 1'b0) || lowerOk(lowerWord, 1'b1))
    else $error("lower limit outside every range");

  start_bad_a: assert property (@(posedge core_clk) disable iff (rst)
    cmdValid && cmdWrite && sel == PVL_SEL_START &&
    cmdWdata[10:0] > 11'h01f |=>
      $stable(startLow_ff) && commFaultFlag && invalidDataFlag ##0 smbAlert)
    else $error("out of range start write not refused");

  stop_order_a: assert property (@(posedge core_clk) disable iff (rst)
    stopReq && stopReqMant > startMant |=> stopReject && !stopAccept &&
    commFaultFlag)
    else $error("stop above start not refused");

endmodule // pvl_limit_regs

// ==== test/pvl_host_model.sv ====
// Purpose: Behavioural bus master handing decoded command cycles to the bank
// Assumes: Requests launch just after a core_clk rising edge
// Notes:   Released lines show the inverse of the last value driven
`timescale 1ns/1ps

module pvl_host_model (
  input  wire logic        core_clk,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic      [7:0]  cmdCode,
  output logic      [15:0] cmdWdata
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdWdata = 16'h0000;
  end

  // A nonzero gap models a slow host; zero gives a request every other cycle
  task automatic send(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, input int unsigned gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode  <= code;
    cmdWdata <= data;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    cmdWrite <= ~wr;
    cmdCode  <= ~code;
    cmdWdata <= ~data;
  endtask
endmodule // pvl_host_model

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the ratio, lower limit and start registers
// Assumes: One host model issues every command, in order
// Notes:   Expected answers queue up in issue order
`timescale 1ns/1ps
`include "pvl_defines.svh"

`define CHK(nm, ex, got) \
  begin \
    nCompared++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end

module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmdValid, cmdWrite, cmdDone, cmdNack, stopAccept, stopReject;
  logic [7:0]  cmdCode;
  logic [15:0] cmdWdata, cmdRdata, refMant, nvRdData, lastL, lastS, r;
  logic        loopSlavePin = 1'b0, outputOn = 1'b0, stopReq = 1'b0;
  logic        targetChange = 1'b0, upperChange = 1'b0, storeAll = 1'b0;
  logic        statusClear = 1'b0, refClamp, ratioHalf, ok;
  logic [15:0] targetMant = 16'h0133, upperMant = 16'h0600;
  logic [10:0] stopMant = 11'h010, stopReqMant = 11'h010;
  logic [1:0]  nvRdAddr = 2'h0;
  logic        otherFaultFlag, outputVoltageSummaryFlag, limitWarnFlag;
  logic        commFaultFlag, invalidDataFlag, invalidCommandFault, smbAlert;
  logic [6:0]  flags;
  logic [17:0] q[$];
  int          failures = 0, nCompared = 0, cycles = 0;
  logic [11:0] lowTab [8] = '{12'h0b2, 12'h0b3, 12'h300, 12'h301,
                              12'h165, 12'h166, 12'h600, 12'h601};
  logic [10:0] stTab [6] = '{11'h010, 11'h011, 11'h01f, 11'h020,
                             11'h013, 11'h014};

  assign flags = {otherFaultFlag, outputVoltageSummaryFlag, limitWarnFlag,
                  commFaultFlag, invalidDataFlag, invalidCommandFault, smbAlert};
  always #50 core_clk = ~core_clk;

  pvl_host_model i_pvl_host_model (.core_clk(core_clk), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata));

  pvl_limit_regs i_pvl_limit_regs (.core_clk(core_clk), .rst(rst),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWdata(cmdWdata), .loopSlavePin(loopSlavePin), .outputOn(outputOn),
    .targetMant(targetMant), .targetChange(targetChange),
    .upperMant(upperMant), .upperChange(upperChange), .stopMant(stopMant),
    .stopReq(stopReq), .stopReqMant(stopReqMant), .statusClear(statusClear),
    .storeAll(storeAll), .nvRdAddr(nvRdAddr), .cmdDone(cmdDone),
    .cmdNack(cmdNack), .cmdRdata(cmdRdata), .stopAccept(stopAccept),
    .stopReject(stopReject), .refMant(refMant), .refClamp(refClamp),
    .ratioHalf(ratioHalf), .otherFaultFlag(otherFaultFlag),
    .outputVoltageSummaryFlag(outputVoltageSummaryFlag),
    .limitWarnFlag(limitWarnFlag), .commFaultFlag(commFaultFlag),
    .invalidDataFlag(invalidDataFlag),
    .invalidCommandFault(invalidCommandFault), .smbAlert(smbAlert),
    .nvRdData(nvRdData));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Data of nacked or write answers is not checked
  task automatic cmd(input logic wr, input logic [7:0] code,
                     input logic [15:0] d, input logic nack,
                     input logic [15:0] ex);
    q.push_back({~wr & ~nack, nack, ex});
    i_pvl_host_model.send(wr, code, d, $urandom_range(2));
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic clr();
    @(posedge core_clk);
    statusClear <= 1'b1;
    @(posedge core_clk);
    statusClear <= 1'b0;
    settle();
    `CHK("flagsCleared", 7'h00, flags)
  endtask

  task automatic wchk(input logic [7:0] code, input logic [15:0] d,
                      input logic good, input logic [15:0] rd);
    cmd(1'b1, code, d, 1'b0, 16'h0000);
    settle();
    `CHK("badDataFlags", good ? 7'h00 : 7'h0d, flags)
    cmd(1'b0, code, 16'h0000, 1'b0, rd);
    clr();
  endtask

  task automatic tchg(input logic [15:0] t, input logic [15:0] u);
    @(posedge core_clk);
    targetMant <= t;
    upperMant <= u;
    targetChange <= 1'b1;
    upperChange <= 1'b1;
    @(posedge core_clk);
    targetChange <= 1'b0;
    upperChange <= 1'b0;
    settle();
  endtask

  task automatic stopchk(input logic [10:0] m, input logic [1:0] ex);
    @(posedge core_clk);
    stopReqMant <= m;
    stopReq <= 1'b1;
    @(posedge core_clk);
    stopReq <= 1'b0;
    @(negedge core_clk);
    `CHK("stopAnswer", ex, {stopAccept, stopReject})
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin : mon
    logic [17:0] e;
    if (cmdDone === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("Error cmdDone expected 0 seen 1");
      end else begin
        e = q.pop_front();
        `CHK("cmdNack", e[16], cmdNack)
        if (e[17])
          `CHK("cmdRdata", e[15:0], cmdRdata)
      end
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(79));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    cmd(1'b0, `PVL_CMD_RATIO, 16'h0000, 1'b0, `PVL_RATIO_RESET);
    cmd(1'b0, `PVL_CMD_LOWER, 16'h0000, 1'b0, `PVL_LOWER_RESET);
    cmd(1'b0, `PVL_CMD_START, 16'h0000, 1'b0, `PVL_START_RESET);
    settle();
    `CHK("resetFlags", 7'h00, flags)
    $display("Test reset_values done");
    r = $urandom();
    wchk(`PVL_CMD_RATIO, {r[15:11], 11'h002}, 1'b1, 16'hf002);
    `CHK("ratioHalf", 1'b1, ratioHalf)
    wchk(`PVL_CMD_RATIO, {r[15:11], 11'h003}, 1'b0, 16'hf002);
    wchk(`PVL_CMD_RATIO, {r[10:6], 11'h004}, 1'b1, 16'hf004);
    `CHK("ratioOne", 1'b0, ratioHalf)
    $display("Test feedback_ratio done");
    lastL = 16'h00b3;
    for (int i = 0; i < 8; i++) begin
      // Ratio goes in before the limits that depend on it
      if (i == 4)
        wchk(`PVL_CMD_RATIO, 16'hf002, 1'b1, 16'hf002);
      ok = (i % 4 == 1) || (i % 4 == 2);
      if (ok)
        lastL = {4'h0, lowTab[i]};
      r = $urandom();
      wchk(`PVL_CMD_LOWER, {r[3:0], lowTab[i]}, ok, lastL);
    end
    $display("Test lower_limit_range done");
    lastS = 16'hf012;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      if (i == 4)
        stopMant <= 11'h014;
      ok = (i == 1) || (i == 2) || (i == 5);
      if (ok)
        lastS = {12'hf01, stTab[i][3:0]};
      r = $urandom();
      wchk(`PVL_CMD_START, {r[4:0], stTab[i]}, ok, lastS);
    end
    stopchk(11'h015, 2'b01);
    stopchk(11'h014, 2'b10);
    clr();
    @(posedge core_clk);
    storeAll <= 1'b1;
    @(posedge core_clk);
    storeAll <= 1'b0;
    settle();
    `CHK("storedStart", lastS, nvRdData)
    $display("Test start_threshold done");
    wchk(`PVL_CMD_RATIO, 16'hf004, 1'b1, 16'hf004);
    wchk(`PVL_CMD_LOWER, 16'h00b3, 1'b1, 16'h00b3);
    @(posedge core_clk);
    outputOn <= 1'b1;
    tchg(16'h0064, 16'h0600);
    `CHK("refClamp", 1'b1, refClamp)
    `CHK("refLower", 16'h00b3, refMant)
    `CHK("clampFlags", 7'h71, flags)
    tchg(16'h0064, 16'h0096);
    `CHK("refUpper", 16'h0096, refMant)
    cmd(1'b1, `PVL_CMD_RATIO, 16'hf002, 1'b0, 16'h0000);
    settle();
    `CHK("ratioWhileOn", 1'b1, ratioHalf)
    `CHK("refHalf", 16'h004b, refMant)
    cmd(1'b1, `PVL_CMD_RATIO, 16'hf004, 1'b0, 16'h0000);
    tchg(16'h012c, 16'h0600);
    `CHK("noClamp", 1'b0, refClamp)
    `CHK("refTarget", 16'h012c, refMant)
    @(posedge core_clk);
    outputOn <= 1'b0;
    clr();
    $display("Test clamp done");
    @(posedge core_clk);
    loopSlavePin <= 1'b1;
    settle();
    cmd(1'b0, `PVL_CMD_LOWER, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b1, `PVL_CMD_LOWER, 16'h0200, 1'b1, 16'h0000);
    settle();
    `CHK("slaveFlags", 7'h03, flags)
    @(posedge core_clk);
    loopSlavePin <= 1'b0;
    settle();
    clr();
    cmd(1'b0, `PVL_CMD_LOWER, 16'h0000, 1'b0, 16'h00b3);
    $display("Test loop_slave done");
    i_pvl_host_model.send(1'b0, 8'h36, 16'h0000, 0);
    settle();
    `CHK("pending", 0, q.size())
    $display("Test foreign_code done");
    report_and_stop();
  end
endmodule // testbench
